// *** pif_map.vh ***
/*
 * Register map, field positions and reset values of the peripheral
 * interrupt enable/flag block.
 * Assumes a 32-bit classic Wishbone bus with byte addresses.
 */
`ifndef PIF_MAP_VH
`define PIF_MAP_VH

// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
`define PIF_OFS_ENABLE2      8'h00
`define PIF_OFS_FLAG1        8'h04
`define PIF_OFS_CONTROL      8'h08
`define PIF_OFS_EVT_STATUS   8'h0C
`define PIF_OFS_EVT_MASK     8'h10

// ----------------------------------------------------------------------
// Enable group 2 fields
// ----------------------------------------------------------------------
`define PIF_EN2_DESAT        7
`define PIF_EN2_CONVERTER    6
`define PIF_EN2_UNUSED       5
`define PIF_EN2_OVERTEMP     4
`define PIF_EN2_OUT_OVERVOLT 3
`define PIF_EN2_GATE_UNDERV  2
`define PIF_EN2_IN_OVERVOLT  1
`define PIF_EN2_IN_UNDERVOLT 0
`define PIF_EN2_WMASK        8'hDF

// ----------------------------------------------------------------------
// Flag group 1 fields
// ----------------------------------------------------------------------
`define PIF_FL1_BUS_COLL     5
`define PIF_FL1_SERIAL       4
`define PIF_FL1_CAPCMP2      3
`define PIF_FL1_CAPCMP1      2
`define PIF_FL1_T2_MATCH     1
`define PIF_FL1_T1_ROLL      0
`define PIF_FL1_NBITS        6

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define PIF_CTL_GLOBAL_EN    7
`define PIF_CTL_PERIPH_EN    6

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define PIF_RST_BYTE         8'h00
`define PIF_RST_FLAGS        6'h00
`define PIF_RST_WORD         32'h0000_0000

`endif

// *** pif_wb_slave.v ***
/*
 * Classic Wishbone slave handshake for the peripheral interrupt block.
 * Assumes a single-cycle classic master that holds its request until ack.
 */
module pif_wb_slave (
    input  wire        mclk_in,
    input  wire        rstn_in,
    input  wire        wb_cyc_in,
    input  wire        wb_stb_in,
    input  wire        wb_we_in,
    input  wire        wb_sel0_in,
    output wire        access_out,
    output wire        write_out,
    output reg         wb_ack_out
);

    // ------------------------------------------------------------------
    // Handshake
    // ------------------------------------------------------------------
    // First cycle of a request, used to latch read data
    assign access_out = wb_cyc_in & wb_stb_in & ~wb_ack_out;
    // Write lands on the edge where the master samples ack
    assign write_out  = wb_cyc_in & wb_stb_in & wb_we_in & wb_sel0_in & wb_ack_out;

    always @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            wb_ack_out <= 1'b0;
        end else begin
            wb_ack_out <= access_out;
        end
    end

endmodule // pif_wb_slave

// *** pif_irq_regs.v ***
/*
 * Peripheral interrupt enable group 2 and flag group 1 registers, with
 * control bits, event status/mask and interrupt request generation.
 * Assumes event inputs are synchronous one-cycle pulses or levels on
 * mclk_in, and a classic Wishbone master.
 */
// Our own choices: the Wishbone interface to the registers and the address map.
// How it works
// - Enable group 2 holds desat, converter, unused, overtemp, out-overvolt, gate-undervolt, in-overvolt and in-undervolt from bit 7 down.
// - Each implemented enable bit is read/write, one permits its interrupt, and it resets to zero.
// - Bit 5 of the enable register and bits 7 and 6 of the flag register always read zero.
// - A flag is set by its event whatever the enable bits and global enables hold.
// - Flag group 1 holds bus collision, serial port, capcmp 2, capcmp 1, timer two match and timer one rollover from bit 5 down.
// - The timer two flag sets when the count reaches the period and stays set until software writes zero.
// - The timer one flag sets on rollover and stays set until software clears it.
// - A capcmp flag sets on capture or compare, and all flags are read/write and reset to zero.
// - No peripheral interrupt reaches the core while the peripheral enable is clear.
// - The global enable passes unmasked interrupts to core_irq_out when set and periph_en_q is set, blocks them all when clear; irq_out does not depend on it.
`include "pif_map.vh"

module pif_irq_regs (
    input  wire        mclk_in,
    input  wire        rstn_in,
    // Wishbone slave
    input  wire        wb_cyc_in,
    input  wire        wb_stb_in,
    input  wire        wb_we_in,
    input  wire [7:0]  wb_adr_in,
    input  wire [3:0]  wb_sel_in,
    input  wire [31:0] wb_dat_in,
    output wire        wb_ack_out,
    output reg  [31:0] wb_dat_out,
    // Peripheral events
    input  wire        bus_collision_evt_in,
    input  wire        serial_port_evt_in,
    input  wire        capcmp_unit2_capture_in,
    input  wire        capcmp_unit2_compare_in,
    input  wire        capcmp_unit1_capture_in,
    input  wire        capcmp_unit1_compare_in,
    input  wire [7:0]  timer_two_count_in,
    input  wire [7:0]  timer_two_period_in,
    input  wire        timer_one_rollover_in,
    // Rest of the controller
    input  wire [7:0]  flag_group2_in,
    input  wire [7:0]  enable_group1_in,
    // Outputs
    output reg  [7:0]  enable_group2_out,
    output reg  [7:0]  flag_group1_out,
    output reg         global_irq_en_out,
    output reg         peripheral_irq_global_en_out,
    output reg         core_irq_out,
    output reg         irq_out
);

    // ------------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------------
    wire        access;
    wire        write;

    pif_wb_slave u_slave (
        .mclk_in    (mclk_in),
        .rstn_in    (rstn_in),
        .wb_cyc_in  (wb_cyc_in),
        .wb_stb_in  (wb_stb_in),
        .wb_we_in   (wb_we_in),
        .wb_sel0_in (wb_sel_in[0]),
        .access_out (access),
        .write_out  (write),
        .wb_ack_out (wb_ack_out)
    );

    // Word offsets, compared on address bits 7:2 only
    localparam [7:0] OFS_EN2    = `PIF_OFS_ENABLE2;
    localparam [7:0] OFS_FL1    = `PIF_OFS_FLAG1;
    localparam [7:0] OFS_CTL    = `PIF_OFS_CONTROL;
    localparam [7:0] OFS_STATUS = `PIF_OFS_EVT_STATUS;
    localparam [7:0] OFS_MASK   = `PIF_OFS_EVT_MASK;

    wire        wr_enable2;
    wire        wr_flag1;
    wire        wr_control;
    wire        wr_status;
    wire        wr_mask;

    assign wr_enable2 = write & (wb_adr_in[7:2] == OFS_EN2[7:2]);
    assign wr_flag1   = write & (wb_adr_in[7:2] == OFS_FL1[7:2]);
    assign wr_control = write & (wb_adr_in[7:2] == OFS_CTL[7:2]);
    assign wr_status  = write & (wb_adr_in[7:2] == OFS_STATUS[7:2]);
    assign wr_mask    = write & (wb_adr_in[7:2] == OFS_MASK[7:2]);

    // ------------------------------------------------------------------
    // Event detection
    // ------------------------------------------------------------------
    reg         t2_equal_q;
    wire        t2_equal;
    wire        t2_match;
    wire [5:0]  evt;

    assign t2_equal = (timer_two_count_in == timer_two_period_in);
    // Only the arrival at the period counts, not the time spent there
    assign t2_match = t2_equal & ~t2_equal_q;

    always @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            t2_equal_q <= 1'b0;
        end else begin
            t2_equal_q <= t2_equal;
        end
    end

    assign evt[`PIF_FL1_BUS_COLL] = bus_collision_evt_in;
    assign evt[`PIF_FL1_SERIAL]   = serial_port_evt_in;
    assign evt[`PIF_FL1_CAPCMP2]  = capcmp_unit2_capture_in | capcmp_unit2_compare_in;
    assign evt[`PIF_FL1_CAPCMP1]  = capcmp_unit1_capture_in | capcmp_unit1_compare_in;
    assign evt[`PIF_FL1_T2_MATCH] = t2_match;
    assign evt[`PIF_FL1_T1_ROLL]  = timer_one_rollover_in;

    // ------------------------------------------------------------------
    // Flag group 1 and event status, one slice per bit
    // ------------------------------------------------------------------
    reg  [5:0]  flag_q;
    reg  [5:0]  status_q;
    reg  [5:0]  mask_q;

    genvar i;
    generate
        for (i = 0; i < `PIF_FL1_NBITS; i = i + 1) begin : g_flag
            // Event set wins over a software write in the same cycle
            always @(posedge mclk_in or negedge rstn_in) begin
                if (!rstn_in) begin
                    flag_q[i] <= 1'b0;
                end else if (evt[i]) begin
                    flag_q[i] <= 1'b1;
                end else if (wr_flag1) begin
                    flag_q[i] <= wb_dat_in[i];
                end
            end

            // Sticky status, cleared by writing one
            always @(posedge mclk_in or negedge rstn_in) begin
                if (!rstn_in) begin
                    status_q[i] <= 1'b0;
                end else if (evt[i]) begin
                    status_q[i] <= 1'b1;
                end else if (wr_status & wb_dat_in[i]) begin
                    status_q[i] <= 1'b0;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Enable group 2, control and mask registers
    // ------------------------------------------------------------------
    reg  [7:0]  enable2_q;
    reg         global_en_q;
    reg         periph_en_q;

    always @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            enable2_q   <= `PIF_RST_BYTE;
            global_en_q <= 1'b0;
            periph_en_q <= 1'b0;
            mask_q      <= `PIF_RST_FLAGS;
        end else begin
            if (wr_enable2) begin
                // Unused bit 5 never stores
                enable2_q <= wb_dat_in[7:0] & `PIF_EN2_WMASK;
            end
            if (wr_control) begin
                global_en_q <= wb_dat_in[`PIF_CTL_GLOBAL_EN];
                periph_en_q <= wb_dat_in[`PIF_CTL_PERIPH_EN];
            end
            if (wr_mask) begin
                mask_q <= wb_dat_in[5:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    reg  [31:0] rdata;

    always @* begin
        rdata = `PIF_RST_WORD;
        case (wb_adr_in[7:2])
            OFS_EN2[7:2]: begin
                rdata[7:0] = enable2_q;
            end
            OFS_FL1[7:2]: begin
                rdata[7:0] = {2'b00, flag_q};
            end
            OFS_CTL[7:2]: begin
                rdata[`PIF_CTL_GLOBAL_EN] = global_en_q;
                rdata[`PIF_CTL_PERIPH_EN] = periph_en_q;
            end
            OFS_STATUS[7:2]: begin
                rdata[5:0] = status_q;
            end
            OFS_MASK[7:2]: begin
                rdata[5:0] = mask_q;
            end
            default: begin
                rdata = `PIF_RST_WORD;
            end
        endcase
    end

    always @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            wb_dat_out <= `PIF_RST_WORD;
        end else if (access) begin
            wb_dat_out <= rdata;
        end
    end

    // ------------------------------------------------------------------
    // Interrupt request generation
    // ------------------------------------------------------------------
    wire        pend_group1;
    wire        pend_group2;
    wire        core_irq_d;

    assign pend_group1 = |(flag_q & enable_group1_in[5:0]);
    assign pend_group2 = |(flag_group2_in & enable2_q);
    // Both enables must be set before any peripheral request passes
    assign core_irq_d  = global_en_q & periph_en_q & (pend_group1 | pend_group2);

    always @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            core_irq_out                 <= 1'b0;
            irq_out                      <= 1'b0;
            enable_group2_out            <= `PIF_RST_BYTE;
            flag_group1_out              <= `PIF_RST_BYTE;
            global_irq_en_out            <= 1'b0;
            peripheral_irq_global_en_out <= 1'b0;
        end else begin
            core_irq_out                 <= core_irq_d;
            irq_out                      <= |(status_q & mask_q);
            enable_group2_out            <= enable2_q;
            flag_group1_out              <= {2'b00, flag_q};
            global_irq_en_out            <= global_en_q;
            peripheral_irq_global_en_out <= periph_en_q;
        end
    end

endmodule // pif_irq_regs

// *** pif_irq_regs_dummy_guard.v ***
/*
 * Intentionally empty companion; holds no logic.
 * Assumes nothing.
 */

// *** pif_irq_regs_checker.sv ***
/* Port assertions for the peripheral interrupt register block.
   Assumes one clock domain and the active-low asynchronous reset. */
module pif_irq_regs_checker (
    input logic        mclk_in,
    input logic        rstn_in,
    input logic        wb_cyc_in,
    input logic        wb_stb_in,
    input logic        wb_we_in,
    input logic [7:0]  wb_adr_in,
    input logic [3:0]  wb_sel_in,
    input logic [31:0] wb_dat_in,
    input logic        wb_ack_out,
    input logic        serial_port_evt_in,
    input logic        capcmp_unit1_capture_in,
    input logic        capcmp_unit1_compare_in,
    input logic [7:0]  timer_two_count_in,
    input logic [7:0]  timer_two_period_in,
    input logic        timer_one_rollover_in,
    input logic [7:0]  flag_group2_in,
    input logic [7:0]  enable_group1_in,
    input logic [7:0]  enable_group2_out,
    input logic [7:0]  flag_group1_out,
    input logic        global_irq_en_out,
    input logic        peripheral_irq_global_en_out,
    input logic        core_irq_out,
    input logic        irq_out
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rstn_in);
    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    wire wr_cyc = wb_ack_out && wb_cyc_in && wb_stb_in && wb_we_in && wb_sel_in[0];
    wire t2_eq  = timer_two_count_in == timer_two_period_in;
    a_serial_flag_set: assert property (serial_port_evt_in |-> ##2 flag_group1_out[4])
        else $error("serial flag not set");
    a_capcmp_flag_set: assert property ((capcmp_unit1_capture_in || capcmp_unit1_compare_in)
        |-> ##2 flag_group1_out[2]) else $error("capcmp flag not set");
    a_rollover_flag_set: assert property (timer_one_rollover_in |-> ##2 flag_group1_out[0])
        else $error("rollover flag not set");
    a_match_flag_set: assert property (t2_eq && !$past(t2_eq) |-> ##[2:3] flag_group1_out[1])
        else $error("match flag not set");
    a_unused_bits_zero: assert property (flag_group1_out[7:6] == 2'h0 && !enable_group2_out[5])
        else $error("unused bit set");
    a_enable_write_lands: assert property (wr_cyc && wb_adr_in[7:2] == 6'h00 |->
        ##2 enable_group2_out == ($past(wb_dat_in[7:0], 2) & 8'hDF))
        else $error("enable write wrong");
    a_flag_only_sw_clear: assert property ($fell(flag_group1_out[0]) |->
        $past(wr_cyc && wb_adr_in[7:2] == 6'h01, 2)) else $error("flag dropped");
    a_core_irq_gated: assert property (core_irq_out |->
        global_irq_en_out && peripheral_irq_global_en_out) else $error("irq ungated");
    a_core_irq_cause: assert property (core_irq_out == (global_irq_en_out
        && peripheral_irq_global_en_out && ((|(flag_group1_out[5:0] & $past(enable_group1_in[5:0])))
        || (|($past(flag_group2_in) & enable_group2_out))))) else $error("irq wrong");
    c_core_irq: cover property ($rose(core_irq_out));
    c_evt_irq: cover property ($rose(irq_out));
    c_flag_clear: cover property ($fell(flag_group1_out[0]));
endmodule // pif_irq_regs_checker

bind pif_irq_regs pif_irq_regs_checker pif_irq_regs_checker_inst (.mclk_in, .rstn_in,
    .wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_adr_in, .wb_sel_in, .wb_dat_in, .wb_ack_out,
    .serial_port_evt_in, .capcmp_unit1_capture_in, .capcmp_unit1_compare_in,
    .timer_two_count_in, .timer_two_period_in, .timer_one_rollover_in, .flag_group2_in,
    .enable_group1_in, .enable_group2_out, .flag_group1_out, .global_irq_en_out,
    .peripheral_irq_global_en_out, .core_irq_out, .irq_out);

// *** test_pif_irq_regs.sv ***
/* Self-checking bench for the peripheral interrupt register block.
   Assumes the register map of the block header and a classic bus. */
module test_pif_irq_regs;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk_in, rstn_in, cyc, stb, we;
    logic [7:0]  adr, t2c, t2p, fl2, en1, en2_o, fl1_o;
    logic [3:0]  sel;
    logic [31:0] dat, rdat;
    logic        ack, bc, sp, c2a, c2b, c1a, c1b, t1, ge, pe, cirq, irq;
    int          n_errors = 0, cmp_count = 0;
    logic [31:0] rd;
    pif_irq_regs pif_irq_regs_inst (.mclk_in, .rstn_in, .wb_cyc_in(cyc), .wb_stb_in(stb),
        .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(dat), .wb_ack_out(ack),
        .wb_dat_out(rdat), .bus_collision_evt_in(bc), .serial_port_evt_in(sp),
        .capcmp_unit2_capture_in(c2a), .capcmp_unit2_compare_in(c2b),
        .capcmp_unit1_capture_in(c1a), .capcmp_unit1_compare_in(c1b),
        .timer_two_count_in(t2c), .timer_two_period_in(t2p), .timer_one_rollover_in(t1),
        .flag_group2_in(fl2), .enable_group1_in(en1), .enable_group2_out(en2_o),
        .flag_group1_out(fl1_o), .global_irq_en_out(ge), .peripheral_irq_global_en_out(pe),
        .core_irq_out(cirq), .irq_out(irq));
    initial begin
        mclk_in = 0;
        forever #5 mclk_in = ~mclk_in;
    end
    task automatic check(input string nm, input logic [31:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
                       input logic [3:0] s);
        @(posedge mclk_in);
        {cyc, stb, we, adr, dat, sel} <= {2'b11, w, a, d, s};
        do @(posedge mclk_in); while (ack !== 1'b1);
        rd = rdat;
        {cyc, stb, we} <= 3'b000;
        @(posedge mclk_in);
    endtask
    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        bus(a, 1'b0, 32'h0000_0000, 4'hF);
        check(nm, rd, e);
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge mclk_in);
        @(negedge mclk_in);
    endtask
    task automatic pulse(input int k);
        @(posedge mclk_in);
        case (k)
            0: bc <= 1'b1;
            1: sp <= 1'b1;
            2: c2a <= 1'b1;
            3: c2b <= 1'b1;
            4: c1a <= 1'b1;
            5: c1b <= 1'b1;
            6: t1 <= 1'b1;
            default: t2c <= t2p;
        endcase
        @(posedge mclk_in);
        {bc, sp, c2a, c2b, c1a, c1b, t1} <= 7'h00;
        settle(3);
    endtask
    task automatic t_reset_regs;
        for (int a = 0; a < 5; a++) rchk("reset", 8'(a * 4), 32'h0000_0000);
    endtask
    task automatic t_enable;
        bus(8'h00, 1'b1, 32'h0000_00FF, 4'h1);
        rchk("en2", 8'h00, 32'h0000_00DF);
        check("en2 out", en2_o, 8'hDF);
        bus(8'h00, 1'b1, 32'h0000_0000, 4'hE);
        rchk("en2 nosel", 8'h00, 32'h0000_00DF);
        bus(8'h00, 1'b1, 32'h0000_0000, 4'h1);
        rchk("en2 clr", 8'h00, 32'h0000_0000);
        bus(8'h20, 1'b1, 32'h0000_00FF, 4'h1);
        rchk("unmapped", 8'h20, 32'h0000_0000);
    endtask
    task automatic t_flags;
        int pos[8] = '{5, 4, 3, 3, 2, 2, 0, 1};
        for (int k = 0; k < 8; k++) begin
            pulse(k);
            rchk("flag set", 8'h04, 32'h1 << pos[k]);
            check("flag out", fl1_o, 8'h1 << pos[k]);
            bus(8'h04, 1'b1, 32'h0000_0000, 4'h1);
            settle(4);
            rchk("flag sticky", 8'h04, 32'h0000_0000);
        end
        bus(8'h04, 1'b1, 32'h0000_00FF, 4'h1);
        rchk("flag rw", 8'h04, 32'h0000_003F);
        rchk("status", 8'h0C, 32'h0000_003F);
    endtask
    task automatic t_core_irq;
        bus(8'h04, 1'b1, 32'h0000_0000, 4'h1);
        en1 <= 8'h10;
        bus(8'h04, 1'b1, 32'h0000_0010, 4'h1);
        bus(8'h08, 1'b1, 32'h0000_00C0, 4'h1);
        settle(3);
        check("irq on", cirq, 1'b1);
        check("enables out", {ge, pe}, 2'b11);
        rchk("control", 8'h08, 32'h0000_00C0);
        bus(8'h08, 1'b1, 32'h0000_0080, 4'h1);
        settle(3);
        check("irq periph off", cirq, 1'b0);
        bus(8'h08, 1'b1, 32'h0000_0040, 4'h1);
        settle(3);
        check("irq global off", cirq, 1'b0);
        bus(8'h08, 1'b1, 32'h0000_00C0, 4'h1);
        bus(8'h04, 1'b1, 32'h0000_0000, 4'h1);
        settle(3);
        check("irq flag clr", cirq, 1'b0);
        fl2 <= 8'h80;
        bus(8'h00, 1'b1, 32'h0000_0080, 4'h1);
        settle(3);
        check("irq group2", cirq, 1'b1);
        fl2 <= 8'h00;
    endtask
    task automatic t_evt_irq;
        bus(8'h10, 1'b1, 32'h0000_0010, 4'h1);
        settle(3);
        check("evt irq", irq, 1'b1);
        bus(8'h0C, 1'b1, 32'h0000_0010, 4'h1);
        rchk("w1c", 8'h0C, 32'h0000_002F);
        settle(2);
        check("evt irq clr", irq, 1'b0);
    endtask
    task automatic test_done;
        $display("comparisons %0d errors %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        #200us;
        n_errors++;
        test_done();
    end
    initial begin
        {rstn_in, cyc, stb, we, adr, dat, sel, bc, sp, c2a, c2b, c1a, c1b, t1} = '0;
        {t2c, fl2, en1} = '0;
        t2p = 8'h5A;
        repeat (6) @(posedge mclk_in);
        rstn_in <= 1'b1;
        t_reset_regs();
        t_enable();
        t_flags();
        t_core_irq();
        t_evt_irq();
        test_done();
    end
endmodule // test_pif_irq_regs
